// ===== verilog/rer_regs.svh
// Register offsets, field positions, codes and reset values of the RAM error records.
`ifndef RER_REGS_SVH
`define RER_REGS_SVH
`define RER_REC_COUNT 13
`define RER_REC_PEND 0
`define RER_REC_SH_CE 1
`define RER_REC_SH_UE 2
`define RER_REC_SI_CE 3
`define RER_REC_SI_UE 4
`define RER_REC_PC_CE 7
`define RER_REC_PC_UE 8
`define RER_REC_LC_CE 9
`define RER_REC_LC_UE 10
`define RER_REC_TS_CE 11
`define RER_REC_TS_UE 12
`define RER_OFF_STATUS 4'h0
`define RER_OFF_MISC0 4'h4
`define RER_OFF_MISC1 4'h8
`define RER_OFF_SH_BITMAP 10'h100
`define RER_OFF_PC_BITMAP 10'h200
`define RER_OFF_CTRL 10'h300
`define RER_OFF_NSACC 10'h304
`define RER_ST_VALID 0
`define RER_ST_OVF 1
`define RER_ST_CODE_LSB 8
`define RER_ST_SEV_LSB 16
`define RER_CODE_BLOCK_WB 8'h45
`define RER_CODE_SUBBLK_RD 8'h46
`define RER_CODE_SUBBLK_WB 8'h47
`define RER_SEV_MEMORY 8'h12
`define RER_TARGET_LSB 16
`define RER_PC_BITLOC_LSB 12
`define RER_PC_OFFSET_LSB 8
`define RER_PC_SOFT_BIT 7
`define RER_LC_BITLOC_LSB 15
`define RER_LC_LOCK_BIT 14
`define RER_LC_PEND_LSB 12
`define RER_LC_BANK_LSB 10
`define RER_CTRL_UE_RST 1'b1
`define RER_NSACC_RST 2'h0
`endif

// ===== verilog/rer_pkg.sv
// Types shared by the RAM error record logic.
`default_nettype none
package rer_pkg;
    // Kind of failed pending-table memory access.
    typedef enum logic [1:0] {
        pend_block_writeback_fail,
        pend_subblock_read_fail,
        pend_subblock_writeback_fail
    } rer_pend_fail_t;
    // One register word.
    typedef logic [31:0] rer_word_t;
endpackage : rer_pkg
`default_nettype wire

// ===== verilog/rer_error_records.sv
// Error records, errored bitmaps and safe-default control for config RAMs.
//
// The implementer's own choices: the Avalon-MM slave port and the address map.
`include "rer_regs.svh"
`default_nettype none
// Operation
// - Block write-back fail logs 0x45, severity 0x12
// - Sub-block read fail logs 0x46, data used
// - Sub-block write-back fail logs 0x47, continue
// - Shared RAM errors: record 1/2, notify
// - Records 1-2 only with shared ECC
// - ID bit 0 picks RAM, ID>>1 row
// - Shared syndrome: bit location or ID
// - Uncorrectable shared interrupt flagged, forced safe
// - Write-1 clears flag, restores defaults
// - Corrupted register read errors unless disabled
// - Softint RAM errors: records 3/4 if configured
// - Syndrome address names softint RAM row
// - Per-core write-1 clears, restores softint defaults
// - Per-core RAM errors: records 7/8
// - Per-core syndrome field layout
// - Cache errors: records 9/10, notify
// - Cache syndrome: lock, pending, bank, address
// - Uncorrectable cache line dumped, then dropped
// - Per-core error overwrites non-secure access
// - Translation RAM records 11/12, refetch
module rer_error_records #(
    parameter int N_SHARED = 64,
    parameter int N_CORE = 4,
    parameter int SI_ROW_W = 6,
    parameter bit SHARED_ECC = 1'b1,
    parameter bit SOFTINT_ECC = 1'b1,
    parameter bit PERCORE_ECC = 1'b1,
    parameter bit CACHE_ECC = 1'b1,
    parameter bit XLAT_PRESENT = 1'b1,
    parameter int ID_W = $clog2(N_SHARED)
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    // Avalon-MM slave, byte addressed.
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Pending-table access failures.
    input wire logic pend_fail_valid,
    input wire rer_pkg::rer_pend_fail_t pend_fail_kind,
    input wire logic [15:0] pend_fail_target,
    input wire logic [15:0] pend_fail_id,
    // Shared-interrupt RAM ECC events.
    input wire logic sh_err_valid,
    input wire logic sh_err_uncorr,
    input wire logic [5:0] sh_err_bitloc,
    input wire logic [ID_W-1:0] sh_err_id,
    // Shared-interrupt configuration access to be steered to a RAM.
    input wire logic [ID_W-1:0] sh_cfg_id,
    output logic shared_ram_odd_q,
    output logic [ID_W-2:0] shared_row_q,
    // Softint RAM ECC events.
    input wire logic si_err_valid,
    input wire logic si_err_uncorr,
    input wire logic [5:0] si_err_bitloc,
    input wire logic [SI_ROW_W-1:0] si_err_row,
    // Per-core RAM ECC events.
    input wire logic pc_err_valid,
    input wire logic pc_err_uncorr,
    input wire logic [5:0] pc_err_bitloc,
    input wire logic [3:0] pc_err_offset,
    input wire logic pc_err_softint,
    input wire logic [6:0] pc_err_core,
    // Message-interrupt cache ECC events.
    input wire logic lc_err_valid,
    input wire logic lc_err_uncorr,
    input wire logic [5:0] lc_err_bitloc,
    input wire logic lc_err_locked,
    input wire logic [1:0] lc_err_pending,
    input wire logic [9:0] lc_err_addr,
    input wire logic [31:0] lc_err_line,
    // Translation-service RAM ECC events.
    input wire logic ts_err_valid,
    input wire logic ts_err_uncorr,
    input wire logic [23:0] ts_err_syndrome,
    // Register read path found corrupted programming.
    input wire logic cfg_read_corrupt,
    output logic cfg_read_error_q,
    // Notification per RAM: shared, softint, per-core, cache, translation.
    output logic [4:0] ecc_notify_q,
    output logic [N_SHARED-1:0] shared_errored,
    output logic [N_SHARED-1:0] shared_restore_q,
    output logic [1:0] nonsecure_access_field,
    output logic [N_CORE*32-1:0] percore_errored,
    output logic [N_CORE*16-1:0] percore_softint_restore_q,
    output logic percore_nsacc_overwrite_q,
    output logic [6:0] percore_nsacc_core_q,
    output logic cache_line_drop_q,
    output logic xlat_refetch_q
);
    import rer_pkg::*;

    localparam int NREC = `RER_REC_COUNT;

    // Records that exist in this configuration; 5 and 6 belong elsewhere.
    localparam logic [NREC-1:0] REC_PRESENT = {
        {2{XLAT_PRESENT}}, {2{CACHE_ECC}}, {2{PERCORE_ECC}}, 2'b00,
        {2{SOFTINT_ECC}}, {2{SHARED_ECC}}, 1'b1};

    logic ack_q; // Answer phase of the current bus access.
    logic wr_fire; // A write takes effect this edge.
    logic [31:0] wmask; // Write data gated by byte enables.
    logic [31:0] rd_word; // Read mux output.
    logic [31:0] readdata_q; // Registered read data.
    logic [NREC-1:0] evt; // Error event per record this cycle.
    rer_word_t syn [NREC]; // Syndrome proposed per record.
    logic [NREC-1:0] clr; // Software clear per record.
    logic [NREC-1:0] capture; // Record takes new syndrome.
    logic [NREC-1:0] rec_valid_q; // Record holds an error.
    logic [NREC-1:0] rec_ovf_q; // A later error was not captured.
    rer_word_t rec_misc0_q [NREC]; // Captured syndrome word.
    logic [7:0] rec0_code_q; // Implementation error code of record 0.
    logic [7:0] rec0_sev_q; // Severity code of record 0.
    rer_word_t cache_line_dump_word; // Raw corrupted cache line.
    logic ctrl_ue_en_q; // Uncorrectable-error reporting enable.
    logic [1:0] nsacc_q; // Non-secure pend access in errored state.
    logic [N_SHARED-1:0] sh_bitmap_q; // Shared errored bitmap.
    logic [N_CORE*32-1:0] pc_bitmap_q; // Per-core errored bitmap.

    // The bus answers one cycle after a request is seen; read data is
    // registered on the edge where waitrequest is high, write effect where it is low.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read || avs_write) && !ack_q;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign wr_fire = avs_write && ack_q;
    assign wmask = avs_writedata & {{8{avs_byteenable[3]}},
        {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}},
        {8{avs_byteenable[0]}}};

    // Record status words clear on a write of 1 to the valid bit.
    always_comb begin
        clr = '0;
        if (wr_fire && avs_address[9:8] == 2'b00 &&
            avs_address[3:0] == `RER_OFF_STATUS &&
            32'(avs_address[7:4]) < NREC) begin
            clr[avs_address[7:4]] = wmask[`RER_ST_VALID];
        end
    end

    // Each ECC source maps onto its correctable record, or the uncorrectable
    // one just above it. Absent records never see events; syndromes only
    // matter where an event captures, so they are built unconditionally.
    always_comb begin
        evt = '0;
        for (int k = 0; k < NREC; k++) begin
            syn[k] = '0;
        end
        evt[`RER_REC_PEND] = pend_fail_valid;
        syn[`RER_REC_PEND] = {pend_fail_target, pend_fail_id};
        if (SHARED_ECC && sh_err_valid) begin
            evt[`RER_REC_SH_CE + int'(sh_err_uncorr)] = 1'b1;
        end
        syn[`RER_REC_SH_UE] = 32'(sh_err_id);
        syn[`RER_REC_SH_CE] = 32'({sh_err_bitloc, sh_err_id});
        if (SOFTINT_ECC && si_err_valid) begin
            evt[`RER_REC_SI_CE + int'(si_err_uncorr)] = 1'b1;
        end
        syn[`RER_REC_SI_UE] = 32'(si_err_row);
        syn[`RER_REC_SI_CE] = 32'({si_err_bitloc, si_err_row});
        if (PERCORE_ECC && pc_err_valid) begin
            evt[`RER_REC_PC_CE + int'(pc_err_uncorr)] = 1'b1;
        end
        for (int k = `RER_REC_PC_CE; k <= `RER_REC_PC_UE; k++) begin
            syn[k][`RER_PC_OFFSET_LSB +: 4] = pc_err_offset;
            syn[k][`RER_PC_SOFT_BIT] = pc_err_softint;
            syn[k][6:0] = pc_err_core;
        end
        syn[`RER_REC_PC_CE][`RER_PC_BITLOC_LSB +: 6] = pc_err_bitloc;
        if (CACHE_ECC && lc_err_valid) begin
            evt[`RER_REC_LC_CE + int'(lc_err_uncorr)] = 1'b1;
        end
        // The bank field stays zero: only one cache bank is built.
        for (int k = `RER_REC_LC_CE; k <= `RER_REC_LC_UE; k++) begin
            syn[k][`RER_LC_LOCK_BIT] = lc_err_locked;
            syn[k][`RER_LC_PEND_LSB +: 2] = lc_err_pending;
            syn[k][9:0] = lc_err_addr;
        end
        syn[`RER_REC_LC_CE][`RER_LC_BITLOC_LSB +: 6] = lc_err_bitloc;
        if (XLAT_PRESENT && ts_err_valid) begin
            evt[`RER_REC_TS_CE + int'(ts_err_uncorr)] = 1'b1;
        end
        syn[`RER_REC_TS_CE] = 32'(ts_err_syndrome);
        syn[`RER_REC_TS_UE] = 32'(ts_err_syndrome);
    end

    // A record captures when empty or cleared in the same cycle, so an
    // error meeting a clear is kept rather than lost.
    assign capture = evt & (~rec_valid_q | clr);

    // One tracker per record; absent records stay empty for good.
    for (genvar r = 0; r < NREC; r++) begin : g_rec
        always_ff @(posedge sys_clk) begin
            if (!rst_b || !REC_PRESENT[r]) begin
                rec_valid_q[r] <= 1'b0;
                rec_ovf_q[r] <= 1'b0;
                rec_misc0_q[r] <= '0;
            end else if (capture[r]) begin
                rec_valid_q[r] <= 1'b1;
                rec_ovf_q[r] <= 1'b0;
                rec_misc0_q[r] <= syn[r];
            end else if (evt[r]) begin
                rec_ovf_q[r] <= 1'b1;
            end else if (clr[r]) begin
                rec_valid_q[r] <= 1'b0;
                rec_ovf_q[r] <= 1'b0;
            end
        end
    end

    // Record 0 also keeps the code and severity of the failed access.
    // Nothing here stalls the pending logic: it always carries on.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rec0_code_q <= 8'h00;
            rec0_sev_q <= 8'h00;
        end else if (capture[`RER_REC_PEND]) begin
            rec0_sev_q <= `RER_SEV_MEMORY;
            case (pend_fail_kind)
                pend_block_writeback_fail: rec0_code_q <= `RER_CODE_BLOCK_WB;
                pend_subblock_read_fail: rec0_code_q <= `RER_CODE_SUBBLK_RD;
                pend_subblock_writeback_fail: begin
                    rec0_code_q <= `RER_CODE_SUBBLK_WB;
                end
                default: rec0_code_q <= 8'h00;
            endcase
        end
    end

    // The raw corrupted line follows the record 10 capture.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cache_line_dump_word <= '0;
        end else if (capture[`RER_REC_LC_UE]) begin
            cache_line_dump_word <= lc_err_line;
        end
    end

    // Side effects that the rest of the controller acts on.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ecc_notify_q <= 5'h00;
            cache_line_drop_q <= 1'b0;
            xlat_refetch_q <= 1'b0;
            percore_nsacc_overwrite_q <= 1'b0;
            percore_nsacc_core_q <= 7'h00;
        end else begin
            ecc_notify_q <= {evt[`RER_REC_TS_CE] | evt[`RER_REC_TS_UE],
                evt[`RER_REC_LC_CE] | evt[`RER_REC_LC_UE],
                evt[`RER_REC_PC_CE] | evt[`RER_REC_PC_UE],
                evt[`RER_REC_SI_CE] | evt[`RER_REC_SI_UE],
                evt[`RER_REC_SH_CE] | evt[`RER_REC_SH_UE]};
            // The line is dropped even if the record was full; any
            // pending interrupts in it are lost either way.
            cache_line_drop_q <= evt[`RER_REC_LC_UE];
            xlat_refetch_q <= evt[`RER_REC_TS_UE];
            percore_nsacc_overwrite_q <= evt[`RER_REC_PC_CE] |
                evt[`RER_REC_PC_UE];
            if (evt[`RER_REC_PC_CE] | evt[`RER_REC_PC_UE]) begin
                percore_nsacc_core_q <= pc_err_core;
            end
        end
    end

    // Configuration accesses are steered by ID parity and row.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            shared_ram_odd_q <= 1'b0;
            shared_row_q <= '0;
        end else begin
            shared_ram_odd_q <= sh_cfg_id[0];
            shared_row_q <= sh_cfg_id[ID_W-1:1];
        end
    end

    // Corrupted reads signal an error only while reporting is enabled.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cfg_read_error_q <= 1'b0;
        end else begin
            cfg_read_error_q <= cfg_read_corrupt && ctrl_ue_en_q;
        end
    end

    // Software-written control: report enable and non-secure access.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ctrl_ue_en_q <= `RER_CTRL_UE_RST;
            nsacc_q <= `RER_NSACC_RST;
        end else if (wr_fire && avs_byteenable[0]) begin
            if (avs_address == `RER_OFF_CTRL) begin
                ctrl_ue_en_q <= avs_writedata[0];
            end else if (avs_address == `RER_OFF_NSACC) begin
                nsacc_q <= avs_writedata[1:0];
            end
        end
    end

    assign nonsecure_access_field = nsacc_q;
    assign shared_errored = sh_bitmap_q;
    assign percore_errored = pc_bitmap_q;

    // Shared errored bits: set by uncorrectable errors, write-1 clears.
    // Set wins over a clear in the same cycle. A clear of a set bit pulses
    // the restore of group, modifier, trigger and access defaults.
    for (genvar i = 0; i < N_SHARED; i++) begin : g_sh
        logic set_b;
        logic clr_b;
        assign set_b = evt[`RER_REC_SH_UE] && sh_err_id == ID_W'(i);
        assign clr_b = wr_fire &&
            avs_address == `RER_OFF_SH_BITMAP + 10'(4 * (i / 32)) &&
            wmask[i % 32];
        always_ff @(posedge sys_clk) begin
            if (!rst_b) begin
                sh_bitmap_q[i] <= 1'b0;
                shared_restore_q[i] <= 1'b0;
            end else begin
                sh_bitmap_q[i] <= set_b || (sh_bitmap_q[i] && !clr_b);
                shared_restore_q[i] <= clr_b && sh_bitmap_q[i];
            end
        end
    end

    // Per-core errored bits: 0-15 softint, 16-31 peripheral per core.
    // An uncorrectable softint RAM row error marks that softint on every core.
    for (genvar j = 0; j < N_CORE * 32; j++) begin : g_pc
        logic set_b;
        logic clr_b;
        assign set_b = (evt[`RER_REC_PC_UE] && pc_err_core == 7'(j / 32) &&
            {!pc_err_softint, pc_err_offset} == 5'(j % 32)) ||
            (evt[`RER_REC_SI_UE] && j % 32 < 16 &&
            si_err_row[3:0] == 4'(j % 32));
        assign clr_b = wr_fire &&
            avs_address == `RER_OFF_PC_BITMAP + 10'(4 * (j / 32)) &&
            wmask[j % 32];
        always_ff @(posedge sys_clk) begin
            if (!rst_b) begin
                pc_bitmap_q[j] <= 1'b0;
            end else begin
                pc_bitmap_q[j] <= set_b || (pc_bitmap_q[j] && !clr_b);
            end
        end
        // Only softint bits restore defaults; peripheral values stay.
        if (j % 32 < 16) begin : g_restore
            always_ff @(posedge sys_clk) begin
                if (!rst_b) begin
                    percore_softint_restore_q[(j/32)*16 + j%32] <= 1'b0;
                end else begin
                    percore_softint_restore_q[(j/32)*16 + j%32] <=
                        clr_b && pc_bitmap_q[j];
                end
            end
        end
    end

    // Read mux; unmapped addresses and absent records read as zero.
    always_comb begin
        rd_word = '0;
        if (avs_address[9:8] == 2'b00) begin
            if (32'(avs_address[7:4]) < NREC) begin
                case (avs_address[3:0])
                    `RER_OFF_STATUS: begin
                        rd_word[`RER_ST_VALID] = rec_valid_q[avs_address[7:4]];
                        rd_word[`RER_ST_OVF] = rec_ovf_q[avs_address[7:4]];
                        if (avs_address[7:4] == 4'h0) begin
                            rd_word[`RER_ST_CODE_LSB +: 8] = rec0_code_q;
                            rd_word[`RER_ST_SEV_LSB +: 8] = rec0_sev_q;
                        end
                    end
                    `RER_OFF_MISC0: rd_word = rec_misc0_q[avs_address[7:4]];
                    `RER_OFF_MISC1: begin
                        if (avs_address[7:4] == 4'(`RER_REC_LC_UE)) begin
                            rd_word = cache_line_dump_word;
                        end
                    end
                    default: rd_word = '0;
                endcase
            end
        end else if (avs_address[9:8] == 2'b01) begin
            // Words beyond the bitmap shift in zeros and read as zero.
            rd_word = 32'(sh_bitmap_q >> (32 * avs_address[7:2]));
        end else if (avs_address[9:8] == 2'b10) begin
            rd_word = 32'(pc_bitmap_q >> (32 * avs_address[7:2]));
        end else if (avs_address == `RER_OFF_CTRL) begin
            rd_word[0] = ctrl_ue_en_q;
        end else if (avs_address == `RER_OFF_NSACC) begin
            rd_word[1:0] = nsacc_q;
        end
    end

    // Read data is latched while waitrequest is high and then stands.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            readdata_q <= 32'h0000_0000;
        end else if (avs_read && !ack_q) begin
            readdata_q <= rd_word;
        end
    end

    assign avs_readdata = readdata_q;
endmodule : rer_error_records
`default_nettype wire

// ===== testbench/rer_error_records_props.sv
// Port-level assertions for the RAM error record block.
`default_nettype none
module rer_error_records_props #(
    parameter int N_SHARED = 64,
    parameter int ID_W = $clog2(N_SHARED)
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic sh_err_valid,
    input wire logic sh_err_uncorr,
    input wire logic [ID_W-1:0] sh_err_id,
    input wire logic [ID_W-1:0] sh_cfg_id,
    input wire logic shared_ram_odd_q,
    input wire logic [ID_W-2:0] shared_row_q,
    input wire logic [N_SHARED-1:0] shared_errored,
    input wire logic [4:0] ecc_notify_q,
    input wire logic cfg_read_corrupt,
    input wire logic cfg_read_error_q,
    input wire logic lc_err_valid,
    input wire logic lc_err_uncorr,
    input wire logic cache_line_drop_q,
    input wire logic ts_err_valid,
    input wire logic ts_err_uncorr,
    input wire logic xlat_refetch_q,
    input wire logic pc_err_valid,
    input wire logic [6:0] pc_err_core,
    input wire logic percore_nsacc_overwrite_q,
    input wire logic [6:0] percore_nsacc_core_q
);
    // One clock domain, so every check shares clock and reset.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // Row and RAM select must be the registered split of the ID.
    property p_steer; 1'b1 |=> {shared_row_q, shared_ram_odd_q} == $past(sh_cfg_id); endproperty
    a_steer: assert property (p_steer) else $error("bad steering");
    property p_sh_note; sh_err_valid |=> ecc_notify_q[0]; endproperty
    a_sh_note: assert property (p_sh_note) else $error("no shared note");
    property p_sh_flag; sh_err_valid && sh_err_uncorr |=> shared_errored[$past(sh_err_id)]; endproperty
    a_sh_flag: assert property (p_sh_flag) else $error("no errored flag");
    // A quiet read path must never raise the error pulse.
    property p_ue_off; !cfg_read_corrupt |=> !cfg_read_error_q; endproperty
    a_ue_off: assert property (p_ue_off) else $error("stray read error");
    property p_lc_note; lc_err_valid |=> ecc_notify_q[3]; endproperty
    a_lc_note: assert property (p_lc_note) else $error("no cache note");
    // Drop pulses exactly when an uncorrectable cache event came in.
    property p_lc_drop; 1'b1 |=> cache_line_drop_q == $past(lc_err_valid && lc_err_uncorr); endproperty
    a_lc_drop: assert property (p_lc_drop) else $error("bad line drop");
    property p_xlat; ts_err_valid && ts_err_uncorr |=> xlat_refetch_q && ecc_notify_q[4]; endproperty
    a_xlat: assert property (p_xlat) else $error("no refetch");
    property p_nsacc; pc_err_valid |=> percore_nsacc_overwrite_q && percore_nsacc_core_q == $past(pc_err_core); endproperty
    a_nsacc: assert property (p_nsacc) else $error("no nsacc overwrite");
    c_sh_ue: cover property (sh_err_valid && sh_err_uncorr);
    c_drop: cover property (cache_line_drop_q);
    c_nsacc: cover property (percore_nsacc_overwrite_q);
endmodule : rer_error_records_props
bind rer_error_records rer_error_records_props #(
    .N_SHARED(N_SHARED), .ID_W(ID_W)) u_props (.*);
`default_nettype wire

// ===== testbench/rer_error_records_tb_top.sv
// Self-checking bench for the RAM error record block.
`default_nettype none
module rer_error_records_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import rer_pkg::*;
    // Event strobes: pend, shared, softint, percore, cache, xlat, corrupt.
    logic [6:0] ev = 7'h0;
    logic ue = 1'b0;
    logic sys_clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic pc_err_softint = 1'b0, lc_err_locked = 1'b0;
    wire pend_fail_valid = ev[0], sh_err_valid = ev[1], si_err_valid = ev[2];
    wire pc_err_valid = ev[3], lc_err_valid = ev[4], ts_err_valid = ev[5];
    wire cfg_read_corrupt = ev[6];
    wire sh_err_uncorr = ue, si_err_uncorr = ue, pc_err_uncorr = ue;
    wire lc_err_uncorr = ue, ts_err_uncorr = ue;
    logic [1:0] lc_err_pending = 2'h0;
    logic [3:0] avs_byteenable = 4'hf, pc_err_offset = 4'h0;
    logic [5:0] sh_err_bitloc = 6'h0, sh_err_id = 6'h0, sh_cfg_id = 6'h0;
    logic [5:0] si_err_bitloc = 6'h0, si_err_row = 6'h0, pc_err_bitloc = 6'h0;
    logic [5:0] lc_err_bitloc = 6'h0;
    logic [6:0] pc_err_core = 7'h0;
    logic [9:0] avs_address = 10'h0, lc_err_addr = 10'h0;
    logic [15:0] pend_fail_target = 16'h0, pend_fail_id = 16'h0;
    logic [23:0] ts_err_syndrome = 24'h0;
    logic [31:0] avs_writedata = 32'h0, lc_err_line = 32'h0;
    rer_pend_fail_t pend_fail_kind = pend_block_writeback_fail;
    rer_word_t avs_readdata;
    logic avs_waitrequest, shared_ram_odd_q, cfg_read_error_q;
    logic percore_nsacc_overwrite_q, cache_line_drop_q, xlat_refetch_q;
    logic [1:0] nonsecure_access_field;
    logic [4:0] shared_row_q, ecc_notify_q;
    logic [6:0] percore_nsacc_core_q;
    logic [63:0] shared_errored, shared_restore_q, percore_softint_restore_q;
    logic [127:0] percore_errored;
    // Expected read words wait here until the monitor sees the data.
    rer_word_t exp_q[$];
    rer_word_t w;
    logic [31:0] seed = 32'hccb0f21e;
    int errors = 0, tests_run = 0, cyc = 0;

    rer_error_records dut (.*);

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    // Next step of the bench's pseudo-random sequence.
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nx
    // One Avalon transfer, held until waitrequest is seen low.
    task automatic bus(input logic wr, input logic [9:0] a, input rer_word_t d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        if (!wr) exp_q.push_back(d);
        do @(posedge sys_clk); while (avs_waitrequest);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    // Raise strobes m for one cycle; kind from k, other fields fresh random (pc_err_core bits 1:0 only).
    task automatic fire(input logic [6:0] m, input logic u, input int k);
        @(posedge sys_clk);
        seed = nx(seed);
        ev <= m;
        ue <= u;
        pend_fail_kind <= rer_pend_fail_t'(k[1:0]);
        {pend_fail_target, pend_fail_id} <= seed;
        {sh_cfg_id, si_err_row, si_err_bitloc, sh_err_id, sh_err_bitloc} <= seed;
        {lc_err_addr, lc_err_pending, lc_err_locked} <= seed[31:19];
        {pc_err_core[1:0], pc_err_softint, pc_err_offset} <= seed[18:12];
        {lc_err_bitloc, pc_err_bitloc} <= seed[11:0];
        lc_err_line <= ~seed;
        ts_err_syndrome <= seed[31:8];
        @(posedge sys_clk);
        ev <= 7'h0;
    endtask : fire
    // The corrupt-read pulse follows the report enable.
    task automatic corrupt(input logic e);
        fire(7'h40, 1'b0, 0);
        @(negedge sys_clk);
        tests_run++;
        if (cfg_read_error_q !== e) begin
            errors++;
            $display("unexpected at %0t: read error pulse", $time);
        end
    endtask : corrupt
    task automatic summarize;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize
    // Monitor: each accepted read takes the oldest expected word.
    always @(posedge sys_clk) begin
        if (avs_read && !avs_waitrequest) begin
            tests_run++;
            if (avs_readdata !== exp_q.pop_front()) begin
                errors++;
                $display("unexpected at %0t: %h read %h", $time, avs_address,
                    avs_readdata);
            end
        end
        cyc++;
        if (cyc == 6000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        bus(0, 10'h304, 32'h0);
        bus(0, 10'h3f0, 32'h0);
        bus(0, 10'h050, 32'h0);
        corrupt(1'b1);
        // Every pending failure kind; the last one overflows its record.
        for (int k = 0; k < 3; k++) begin
            fire(7'h01, 1'b0, k);
            w = {pend_fail_target, pend_fail_id};
            if (k == 2) fire(7'h01, 1'b0, 0);
            bus(0, 10'h0, {8'h0, 8'h12, 8'h45 + k[7:0], 6'h0, k[1], 1'b1});
            bus(0, 10'h4, w);
            bus(1, 10'h0, 32'h1);
            bus(0, 10'h0, {8'h0, 8'h12, 8'h45 + k[7:0], 8'h0});
        end
        fire(7'h02, 1'b1, 0);
        bus(0, 10'h024, {26'h0, sh_err_id});
        bus(0, {7'h20, sh_err_id[5], 2'h0}, 32'h1 << sh_err_id[4:0]);
        bus(1, {7'h20, sh_err_id[5], 2'h0}, 32'h1 << sh_err_id[4:0]);
        bus(0, {7'h20, sh_err_id[5], 2'h0}, 32'h0);
        fire(7'h02, 1'b0, 0);
        bus(0, 10'h014, {20'h0, sh_err_bitloc, sh_err_id});
        fire(7'h04, 1'b1, 0);
        bus(0, 10'h044, {26'h0, si_err_row});
        bus(0, 10'h200, 32'h1 << si_err_row[3:0]);
        for (int c = 0; c < 4; c++) bus(1, 10'h200 + c * 4, 32'hffffffff);
        bus(0, 10'h200, 32'h0);
        fire(7'h04, 1'b0, 0);
        bus(0, 10'h034, {20'h0, si_err_bitloc, si_err_row});
        fire(7'h08, 1'b0, 0);
        bus(0, 10'h074, {14'h0, pc_err_bitloc, pc_err_offset, pc_err_softint, pc_err_core});
        fire(7'h08, 1'b1, 0);
        bus(0, 10'h084, {20'h0, pc_err_offset, pc_err_softint, pc_err_core});
        bus(0, {6'h20, pc_err_core[1:0], 2'h0}, 32'h1 << {!pc_err_softint, pc_err_offset});
        bus(1, {6'h20, pc_err_core[1:0], 2'h0}, 32'hffffffff);
        bus(0, {6'h20, pc_err_core[1:0], 2'h0}, 32'h0);
        fire(7'h10, 1'b1, 0);
        bus(0, 10'h0a4, {17'h0, lc_err_locked, lc_err_pending, 2'h0, lc_err_addr});
        bus(0, 10'h0a8, lc_err_line);
        fire(7'h10, 1'b0, 0);
        bus(0, 10'h094, {11'h0, lc_err_bitloc, lc_err_locked, lc_err_pending, 2'h0, lc_err_addr});
        fire(7'h20, 1'b1, 0);
        bus(0, 10'h0c4, {8'h0, ts_err_syndrome});
        bus(1, 10'h300, 32'h0);
        bus(0, 10'h300, 32'h0);
        corrupt(1'b0);
        summarize();
    end
endmodule : rer_error_records_tb_top
`default_nettype wire
